// [hdl/fpal_pkg.sv]
// constants, encodings and carrier types of the alternate-space fp load unit
package fpal_pkg;

  // instruction fields
  localparam int OP_LSB = 30;
  localparam int RD_LSB = 25;
  localparam int OP3_LSB = 19;
  localparam int RS1_LSB = 14;
  localparam int IBIT_POS = 13;
  localparam int ASI_LSB = 5;
  localparam int RSV_LSB = 5;
  localparam int RSV_W = 8;
  localparam int SIMM_W = 13;
  localparam int RD_QUAD_BAD_BIT = 1;

  localparam logic [1:0] OP_MEM = 2'h3;
  localparam logic [5:0] OP3_LD_SGL_ALT = 6'h30;
  localparam logic [5:0] OP3_LD_DBL_ALT = 6'h33;
  localparam logic [5:0] OP3_LD_QUAD_ALT = 6'h32;
  localparam logic [5:0] OP3_LD_FSR = 6'h21;
  localparam logic [4:0] RD_FSR_LOWER = 5'h00;
  localparam logic [4:0] RD_FSR_FULL = 5'h01;

  // address space identifiers
  localparam int ASI_PRIV_BIT = 7;
  localparam logic [7:0] ASI_LE_MASK = 8'h08;
  localparam logic [7:0] ASI_RSV_LO = 8'h30;
  localparam logic [7:0] ASI_RSV_HI = 8'h7F;
  localparam logic [7:0] ASI_NUCLEUS = 8'h04;
  localparam logic [7:0] ASI_AIU_PRIM = 8'h10;
  localparam logic [7:0] ASI_AIU_SEC = 8'h11;
  localparam logic [7:0] ASI_REAL = 8'h14;
  localparam logic [7:0] ASI_REAL_IO = 8'h15;
  localparam logic [7:0] ASI_PRIM = 8'h80;
  localparam logic [7:0] ASI_SEC = 8'h81;
  localparam logic [7:0] ASI_PRIM_NF = 8'h82;
  localparam logic [7:0] ASI_SEC_NF = 8'h83;
  localparam logic [7:0] ASI_SHORT_LO = 8'hD0;
  localparam logic [7:0] ASI_SHORT_HI = 8'hDB;
  localparam logic [7:0] ASI_SHORT_GAP_MASK = 8'h04;

  // word counts and alignment masks
  localparam logic [2:0] WORDS_SGL = 3'h1;
  localparam logic [2:0] WORDS_DBL = 3'h2;
  localparam logic [2:0] WORDS_QUAD = 3'h4;
  localparam logic [3:0] ALIGN_WORD = 4'h3;
  localparam logic [3:0] ALIGN_DBL = 4'h7;
  localparam logic [3:0] ALIGN_QUAD = 4'hF;
  localparam logic [7:0] WORD_BYTES = 8'h04;

  localparam logic [2:0] FTT_INVALID_FP_REG = 3'h6;

  // register port offsets
  localparam logic [3:0] REG_FSR_LO = 4'h0;
  localparam logic [3:0] REG_FSR_HI = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  typedef enum logic [3:0] {
    EXC_NONE = 4'h0, EXC_ILLEGAL = 4'h1, EXC_FPU_DISABLED = 4'h2, EXC_OTHER_FP = 4'h3,
    EXC_MISALIGNED = 4'h4, EXC_DBL_MISALIGNED = 4'h5, EXC_QUAD_MISALIGNED = 4'h6,
    EXC_PRIV_ACTION = 4'h7, EXC_DATA_ACCESS = 4'h8
  } fpal_exc_t;

  typedef enum logic [1:0] {KIND_SGL = 2'h0, KIND_DBL = 2'h1, KIND_QUAD = 2'h2, KIND_FSR = 2'h3} fpal_kind_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DRAIN = 2'b01, ST_XFER = 2'b11} fpal_state_t;

  typedef struct packed {logic valid; logic [31:0] instr; logic [63:0] rs1_val; logic [63:0] rs2_val;} fpal_issue_t;
  typedef struct packed {
    logic [7:0] asi_reg; logic [7:0] implicit_asi; logic priv; logic pef; logic fef;
    logic fpu_present; logic fp_operate_instr_busy;
  } fpal_ctx_t;
  typedef struct packed {logic req; logic [63:0] addr; logic [7:0] asi;} fpal_mem_req_t;
  typedef struct packed {logic ack; logic err; logic [31:0] data;} fpal_mem_rsp_t;
  typedef struct packed {logic we; logic [4:0] rd; logic [2:0] nwords; logic [127:0] data;} fpal_fpr_wr_t;
  typedef struct packed {logic valid; logic handoff; fpal_exc_t exc; logic [2:0] ftt;} fpal_res_t;

endpackage : fpal_pkg

// [hdl/fpal_load_unit.sv]
// alternate-space fp loads and lower fp state register load, with exception checks
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module fpal_load_unit
  import fpal_pkg::*;
#(
  parameter int QUAD_IN_HW = 0,
  parameter logic [31:0] FSR_KEEP_MASK = 32'h0047E000
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire fpal_issue_t issue, // instruction and source operands
  input wire fpal_ctx_t ctx, // processor state seen by the checks
  output logic issue_ready, // unit can take an instruction
  output fpal_mem_req_t mem_o, // word request to the load path
  input wire fpal_mem_rsp_t mem_i, // word answer from the load path
  output fpal_fpr_wr_t fpr_o, // fp register file write
  output fpal_res_t res_o, // completion or trap report
  output logic [63:0] fsr_o, // fp state register
  input wire logic [3:0] reg_addr, // register port address
  input wire logic [31:0] reg_wdata, // register port write data
  input wire logic reg_wr, // register port write strobe
  input wire logic reg_rd, // register port read strobe
  output logic [31:0] reg_rdata // register port read data
);

  if (QUAD_IN_HW != 0 && QUAD_IN_HW != 1) begin : g_bad_quad
    $error("QUAD_IN_HW must be 0 or 1");
  end

  typedef struct packed {
    fpal_state_t st;
    fpal_kind_t kind;
    logic [4:0] rd;
    logic le;
    logic [63:0] waddr;
    logic [7:0] asi;
    logic [2:0] idx;
    logic [2:0] nwords;
    logic [127:0] buf_w;
    fpal_fpr_wr_t fpr;
    fpal_res_t res;
    logic [63:0] fp_state_register;
    logic [31:0] rdata;
  } fpal_regs_t;

  fpal_regs_t s_reg;
  fpal_regs_t s_next;

  function automatic logic asi_big_ok(input logic [7:0] a);
    asi_big_ok = (a == ASI_NUCLEUS) || (a == ASI_AIU_PRIM) || (a == ASI_AIU_SEC) ||
                 (a == ASI_REAL) || (a == ASI_REAL_IO) || (a == ASI_PRIM) ||
                 (a == ASI_SEC) || (a == ASI_PRIM_NF) || (a == ASI_SEC_NF);
  endfunction : asi_big_ok

  // spaces that turn the double opcode into a block or short load
  function automatic logic asi_other_variant(input logic [7:0] a);
    logic short_hit;
    logic block_hit;
    short_hit = (a >= ASI_SHORT_LO) && (a <= ASI_SHORT_HI) && ((a & ASI_SHORT_GAP_MASK) == 8'h00);
    block_hit = (a == 8'h16) || (a == 8'h17) || (a == 8'h1E) || (a == 8'h1F) ||
                (a == 8'hF0) || (a == 8'hF1) || (a == 8'hF8) || (a == 8'hF9) ||
                (a == 8'hE0) || (a == 8'hE1);
    asi_other_variant = short_hit || block_hit;
  endfunction : asi_other_variant

  function automatic logic [63:0] swap_bytes64(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[8*b +: 8] = d[8*(7-b) +: 8];
    end
    swap_bytes64 = r;
  endfunction : swap_bytes64

  always_comb begin
    logic [1:0] op;
    logic [5:0] op3;
    logic [4:0] rd;
    logic ibit;
    logic is_sgl;
    logic is_dbl;
    logic is_quad;
    logic is_fsr;
    logic is_alt;
    logic [63:0] ea;
    logic [7:0] asi;
    logic asi_ok;
    logic priv_bad;
    logic [3:0] low;
    fpal_exc_t exc;
    logic handoff;
    logic [127:0] shifted;
    logic [127:0] wdata;
    logic [63:0] dbl;
    op = '0;
    op3 = '0;
    rd = '0;
    ibit = 1'b0;
    is_sgl = 1'b0;
    is_dbl = 1'b0;
    is_quad = 1'b0;
    is_fsr = 1'b0;
    is_alt = 1'b0;
    ea = '0;
    asi = '0;
    asi_ok = 1'b0;
    priv_bad = 1'b0;
    low = '0;
    exc = EXC_NONE;
    handoff = 1'b0;
    shifted = '0;
    wdata = '0;
    dbl = '0;
    s_next = s_reg;
    s_next.fpr.we = 1'b0;
    s_next.res = '0;
    s_next.rdata = '0;

    op = issue.instr[OP_LSB +: 2];
    op3 = issue.instr[OP3_LSB +: 6];
    rd = issue.instr[RD_LSB +: 5];
    ibit = issue.instr[IBIT_POS];
    is_sgl = (op == OP_MEM) && (op3 == OP3_LD_SGL_ALT);
    is_dbl = (op == OP_MEM) && (op3 == OP3_LD_DBL_ALT);
    is_quad = (op == OP_MEM) && (op3 == OP3_LD_QUAD_ALT);
    is_fsr = (op == OP_MEM) && (op3 == OP3_LD_FSR);
    is_alt = is_sgl || is_dbl || is_quad;
    // address and space selection
    if (ibit) begin
      ea = issue.rs1_val + {{(64-SIMM_W){issue.instr[SIMM_W-1]}}, issue.instr[SIMM_W-1:0]};
      asi = ctx.asi_reg;
    end else begin
      ea = issue.rs1_val + issue.rs2_val;
      asi = issue.instr[ASI_LSB +: 8];
    end
    if (is_fsr) begin
      asi = ctx.implicit_asi;
    end
    low = ea[3:0];
    if (is_dbl) begin
      asi_ok = asi_big_ok(asi & ~ASI_LE_MASK);
    end else begin
      asi_ok = asi_big_ok(asi);
    end
    if (ctx.priv) begin
      priv_bad = (asi >= ASI_RSV_LO) && (asi <= ASI_RSV_HI);
    end else begin
      priv_bad = !asi[ASI_PRIV_BIT];
    end

    // one trap reported, highest priority first
    if (is_fsr && rd == RD_FSR_FULL) begin
      handoff = 1'b1;
    end else if (is_fsr && rd != RD_FSR_LOWER) begin
      exc = EXC_ILLEGAL;
    end else if (is_fsr && !ibit && issue.instr[RSV_LSB +: RSV_W] != '0) begin
      exc = EXC_ILLEGAL;
    end else if (is_quad && QUAD_IN_HW == 0) begin
      exc = EXC_ILLEGAL;
    end else if (is_dbl && asi_other_variant(asi)) begin
      handoff = 1'b1;
    end else if (!ctx.fpu_present || !ctx.fef || !ctx.pef) begin
      exc = EXC_FPU_DISABLED;
    end else if (is_quad && rd[RD_QUAD_BAD_BIT]) begin
      exc = EXC_OTHER_FP;
    end else if ((low & ALIGN_WORD) != 4'h0) begin
      exc = EXC_MISALIGNED;
    end else if (is_dbl && (low & ALIGN_DBL) != 4'h0) begin
      exc = EXC_DBL_MISALIGNED;
    end else if (is_quad && (low & ALIGN_QUAD) != 4'h0) begin
      exc = EXC_QUAD_MISALIGNED;
    end else if (is_alt && priv_bad) begin
      exc = EXC_PRIV_ACTION;
    end else if (is_alt && !asi_ok) begin
      exc = EXC_DATA_ACCESS;
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (issue.valid && (is_alt || is_fsr)) begin
          if (handoff) begin
            s_next.res.valid = 1'b1;
            s_next.res.handoff = 1'b1;
          end else if (exc != EXC_NONE) begin
            s_next.res.valid = 1'b1;
            s_next.res.exc = exc;
            s_next.res.ftt = (exc == EXC_OTHER_FP) ? FTT_INVALID_FP_REG : 3'h0;
          end else begin
            s_next.st = is_fsr ? ST_DRAIN : ST_XFER;
            s_next.kind = is_fsr ? KIND_FSR : is_sgl ? KIND_SGL : is_dbl ? KIND_DBL : KIND_QUAD;
            s_next.nwords = (is_sgl || is_fsr) ? WORDS_SGL : is_dbl ? WORDS_DBL : WORDS_QUAD;
            s_next.rd = rd;
            s_next.le = is_dbl && ((asi & ASI_LE_MASK) != 8'h00);
            s_next.waddr = ea;
            s_next.asi = asi;
            s_next.idx = '0;
            s_next.buf_w = '0;
          end
        end
      end
      ST_DRAIN: begin
        if (!ctx.fp_operate_instr_busy) begin
          s_next.st = ST_XFER;
        end
      end
      ST_XFER: begin
        if (mem_i.ack) begin
          shifted = {s_reg.buf_w[95:0], mem_i.data};
          s_next.buf_w = shifted;
          s_next.waddr = s_reg.waddr + {56'h0, WORD_BYTES};
          s_next.idx = s_reg.idx + 3'h1;
          if (mem_i.err) begin
            // nothing was written yet, so destinations stay intact
            s_next.st = ST_IDLE;
            s_next.res.valid = 1'b1;
            s_next.res.exc = EXC_DATA_ACCESS;
          end else if (s_reg.idx == s_reg.nwords - 3'h1) begin
            s_next.st = ST_IDLE;
            s_next.res.valid = 1'b1;
            if (s_reg.kind == KIND_FSR) begin
              s_next.fp_state_register[31:0] = (s_reg.fp_state_register[31:0] & FSR_KEEP_MASK) | (shifted[31:0] & ~FSR_KEEP_MASK);
            end else begin
              dbl = s_reg.le ? swap_bytes64(shifted[63:0]) : shifted[63:0];
              case (s_reg.kind)
                KIND_SGL: wdata = {96'h0, shifted[31:0]};
                KIND_DBL: wdata = {64'h0, dbl};
                default: wdata = shifted;
              endcase
              s_next.fpr.we = 1'b1;
              s_next.fpr.rd = s_reg.rd;
              s_next.fpr.nwords = s_reg.nwords;
              s_next.fpr.data = wdata;
            end
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // register port; a finishing state load wins over a write in the same cycle
    if (reg_wr && !(s_reg.st == ST_XFER && s_next.st == ST_IDLE && s_reg.kind == KIND_FSR)) begin
      if (reg_addr == REG_FSR_LO) begin
        s_next.fp_state_register[31:0] = reg_wdata;
      end else if (reg_addr == REG_FSR_HI) begin
        s_next.fp_state_register[63:32] = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == REG_FSR_LO) begin
        s_next.rdata = s_reg.fp_state_register[31:0];
      end else if (reg_addr == REG_FSR_HI) begin
        s_next.rdata = s_reg.fp_state_register[63:32];
      end else if (reg_addr == REG_STATUS) begin
        s_next.rdata = {24'h0, s_reg.idx, s_reg.kind, 1'b0, s_reg.st};
      end else begin
        s_next.rdata = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign issue_ready = (s_reg.st == ST_IDLE);
  assign mem_o.req = (s_reg.st == ST_XFER);
  assign mem_o.addr = s_reg.waddr;
  assign mem_o.asi = s_reg.asi;
  assign fpr_o = s_reg.fpr;
  assign res_o = s_reg.res;
  assign fsr_o = s_reg.fp_state_register;
  assign reg_rdata = s_reg.rdata;

endmodule : fpal_load_unit

// [test/fpal_load_unit_properties.sv]
// port-level checker of the alternate-space fp load unit
`timescale 1ns/10ps
module fpal_load_unit_properties
  import fpal_pkg::*;
#(
  parameter int QUAD_IN_HW = 0,
  parameter logic [31:0] FSR_KEEP_MASK = 32'h0047E000
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire fpal_issue_t issue, // issue
  input wire fpal_ctx_t ctx, // context
  input wire logic issue_ready, // ready
  input wire fpal_mem_req_t mem_o, // word request
  input wire fpal_mem_rsp_t mem_i, // word answer
  input wire fpal_fpr_wr_t fpr_o, // fp write
  input wire fpal_res_t res_o, // result
  input wire logic [63:0] fsr_o, // state register
  input wire logic [3:0] reg_addr, // reg address
  input wire logic reg_wr // reg write
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic fpu_on;
  logic [5:0] op3;
  logic [63:0] ea;
  logic [7:0] asi;
  // address and space formed independently of the unit
  assign take = issue.valid && issue_ready && issue.instr[31:30] == OP_MEM;
  assign fpu_on = ctx.fpu_present && ctx.pef && ctx.fef;
  assign op3 = issue.instr[24:19];
  assign ea = issue.rs1_val + (issue.instr[IBIT_POS] ? {{51{issue.instr[12]}}, issue.instr[12:0]} : issue.rs2_val);
  assign asi = issue.instr[IBIT_POS] ? ctx.asi_reg : issue.instr[12:5];
  property exc_next(logic c, fpal_exc_t e);
    c |=> res_o.valid && res_o.exc == e;
  endproperty
  a_fpu_off_trap: assert property (exc_next(take && op3 == OP3_LD_SGL_ALT && !fpu_on, EXC_FPU_DISABLED))
    else $error("missing fpu disabled trap");
  a_word_misalign: assert property (exc_next(take && op3 == OP3_LD_SGL_ALT && fpu_on && ea[1:0] != 2'h0,
    EXC_MISALIGNED)) else $error("missing misaligned trap");
  a_dbl_misalign: assert property (exc_next(take && op3 == OP3_LD_DBL_ALT && fpu_on && ea[2:0] == 3'h4
    && asi[7:1] == 7'h40, EXC_DBL_MISALIGNED)) else $error("missing double misaligned trap");
  a_user_priv: assert property (exc_next(take && op3 == OP3_LD_SGL_ALT && fpu_on && ea[1:0] == 2'h0
    && !ctx.priv && !asi[7], EXC_PRIV_ACTION)) else $error("missing privileged action trap");
  a_quad_illegal: assert property (exc_next(take && op3 == OP3_LD_QUAD_ALT && QUAD_IN_HW == 0, EXC_ILLEGAL))
    else $error("quad load not illegal");
  a_trap_no_write: assert property (res_o.valid && res_o.exc != EXC_NONE |-> !fpr_o.we)
    else $error("fp register written on trap");
  a_req_hold: assert property (mem_o.req && !mem_i.ack |=> mem_o.req && $stable(mem_o.addr))
    else $error("word request dropped before answer");
  a_addr_step: assert property (mem_o.req && mem_i.ack && !mem_i.err ##1 mem_o.req
    |-> mem_o.addr == $past(mem_o.addr) + 64'h4) else $error("word address not stepped by four");
  a_drain_wait: assert property (take && op3 == OP3_LD_FSR && ctx.fp_operate_instr_busy ##1 ctx.fp_operate_instr_busy |-> !mem_o.req)
    else $error("state load read before fp operates drained");
  a_fsr_upper: assert property (!$past(reg_wr && reg_addr == REG_FSR_HI) |-> $stable(fsr_o[63:32]))
    else $error("upper state half changed");
  a_fsr_fixed: assert property (!$past(reg_wr && reg_addr == REG_FSR_LO)
    |-> $stable(fsr_o[31:0] & FSR_KEEP_MASK)) else $error("fixed state fields changed");
  c_load_done: cover property (res_o.valid && res_o.exc == EXC_NONE && fpr_o.we);
  c_handoff: cover property (res_o.valid && res_o.handoff);
  c_drain: cover property (take && op3 == OP3_LD_FSR ##1 ctx.fp_operate_instr_busy);
endmodule : fpal_load_unit_properties

bind fpal_load_unit fpal_load_unit_properties #(.QUAD_IN_HW(QUAD_IN_HW), .FSR_KEEP_MASK(FSR_KEEP_MASK)) i_props (
  .core_clk(core_clk), .rst_n(rst_n), .issue(issue), .ctx(ctx), .issue_ready(issue_ready), .mem_o(mem_o),
  .mem_i(mem_i), .fpr_o(fpr_o), .res_o(res_o), .fsr_o(fsr_o), .reg_addr(reg_addr), .reg_wr(reg_wr));

// [test/fpal_mem_model.sv]
// load path and mmu model answering one word request at a time
`timescale 1ns/10ps
module fpal_mem_model
  import fpal_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire fpal_mem_req_t mem_o, // word request
  output fpal_mem_rsp_t mem_i, // word answer
  input wire logic [3:0] lat, // wait cycles before answer
  input wire logic fault // answer with access fault
);
  logic [3:0] cnt_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_i <= '0;
      cnt_reg <= 4'h0;
    end else begin
      mem_i.ack <= 1'b0;
      mem_i.err <= 1'b0;
      // data inverted between answers so a late sample cannot match
      mem_i.data <= ~mem_i.data;
      if (mem_o.req && !mem_i.ack) begin
        if (cnt_reg == lat) begin
          mem_i <= '{1'b1, fault, mem_o.addr[31:0] ^ 32'h5A5A5A5A};
          cnt_reg <= 4'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule : fpal_mem_model

// [test/fpal_load_unit_tb_top.sv]
// testbench of the alternate-space fp load unit
`timescale 1ns/10ps
module fpal_load_unit_tb_top
  import fpal_pkg::*;
;
  localparam logic [31:0] KEEP = 32'h0047E000;
  logic core_clk = 1'b0;
  logic rst_n;
  fpal_issue_t issue;
  fpal_ctx_t ctx;
  logic issue_ready;
  fpal_mem_req_t mem_o;
  fpal_mem_rsp_t mem_i;
  fpal_fpr_wr_t fpr_o;
  fpal_res_t res_o;
  logic [63:0] fsr_o;
  logic [63:0] le;
  logic [3:0] reg_addr;
  logic [3:0] lat;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic fault;
  logic [7:0] seen_asi;
  logic [7:0] good [9] = '{ASI_NUCLEUS, ASI_AIU_PRIM, ASI_AIU_SEC, ASI_REAL, ASI_REAL_IO, ASI_PRIM, ASI_SEC,
    ASI_PRIM_NF, ASI_SEC_NF};
  int err_count = 0;
  int n_checks = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (mem_o.req) seen_asi <= mem_o.asi;
  fpal_load_unit #(.QUAD_IN_HW(0), .FSR_KEEP_MASK(KEEP)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .issue(issue),
    .ctx(ctx), .issue_ready(issue_ready), .mem_o(mem_o), .mem_i(mem_i), .fpr_o(fpr_o), .res_o(res_o), .fsr_o(fsr_o),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fpal_mem_model i_mem (.core_clk(core_clk), .rst_n(rst_n), .mem_o(mem_o), .mem_i(mem_i), .lat(lat), .fault(fault));
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] mw(input logic [63:0] a);
    return a[31:0] ^ 32'h5A5A5A5A;
  endfunction : mw
  function automatic logic [31:0] mk(input logic [4:0] rd, input logic [5:0] o3, input logic i, input logic [12:0] lo);
    return {OP_MEM, rd, o3, 5'h01, i, lo};
  endfunction : mk
  function automatic logic [31:0] s(input logic [7:0] asi);
    return mk(5'h04, OP3_LD_SGL_ALT, 1'b0, {asi, 5'h00});
  endfunction : s
  function automatic logic [31:0] dl(input logic [7:0] asi);
    return mk(5'h04, OP3_LD_DBL_ALT, 1'b0, {asi, 5'h00});
  endfunction : dl
  // waits are bounded; a hang ends the run as a failure
  task automatic run(input logic [31:0] ins, input logic [63:0] a, input fpal_exc_t ex,
                     input logic [127:0] d = '0, input logic hx = 1'b0, input logic [63:0] b = '0);
    int k;
    fpal_res_t r;
    fpal_fpr_wr_t w;
    issue <= '{1'b1, ins, a, b};
    k = 0;
    // outputs are looked at on the falling edge, where they have settled
    do begin
      @(negedge core_clk);
      k++;
    end while (issue_ready !== 1'b1 && k < 50);
    @(posedge core_clk);
    issue.valid <= 1'b0;
    do begin
      @(negedge core_clk);
      k++;
    end while (res_o.valid !== 1'b1 && k < 250);
    if (k >= 250) begin
      err_count++;
      finish_test();
    end else begin
      r = res_o;
      w = fpr_o;
      chk("handoff", r.handoff, hx);
      if (!hx) chk("exc", r.exc, ex);
      chk("we", w.we, ex == EXC_NONE && !hx && ins[24:19] != OP3_LD_FSR);
      if (w.we === 1'b1) chk("data", w.data, d);
      if (w.we === 1'b1) chk("rd", w.rd, ins[29:25]);
      @(posedge core_clk);
    end
  endtask : run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(negedge core_clk);
    chk("reg_rdata", reg_rdata, e);
    @(posedge core_clk);
  endtask : rd
  initial begin
    rst_n = 1'b0;
    issue = '0;
    ctx = '{ASI_PRIM, ASI_PRIM, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lat = 4'h0;
    fault = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    run(s(ASI_PRIM), 64'h100, EXC_NONE, mw(64'h120), 1'b0, 64'h20);
    chk("asi", seen_asi, ASI_PRIM);
    ctx.asi_reg <= ASI_SEC;
    run(mk(5'h04, OP3_LD_SGL_ALT, 1'b1, 13'h1FF8), 64'h208, EXC_NONE, mw(64'h200));
    chk("asi", seen_asi, ASI_SEC);
    lat <= 4'h3;
    run(dl(ASI_PRIM), 64'h500, EXC_NONE, {mw(64'h500), mw(64'h504)});
    lat <= 4'h0;
    le = {mw(64'h500), mw(64'h504)};
    le = {<<8{le}};
    foreach (good[j]) begin
      run(s(good[j]), 64'h500, EXC_NONE, mw(64'h500));
      run(dl(good[j] | ASI_LE_MASK), 64'h500, EXC_NONE, le);
    end
    run(s(8'h20), 64'h500, EXC_DATA_ACCESS);
    run(dl(8'h84), 64'h500, EXC_DATA_ACCESS);
    run(dl(8'hC0), 64'h500, EXC_DATA_ACCESS);
    run(dl(8'hC8), 64'h504, EXC_DBL_MISALIGNED);
    run(s(8'h30), 64'h500, EXC_PRIV_ACTION);
    run(s(8'h7F), 64'h500, EXC_PRIV_ACTION);
    run(s(8'h2F), 64'h500, EXC_DATA_ACCESS);
    ctx.priv <= 1'b0;
    run(s(ASI_AIU_PRIM), 64'h500, EXC_PRIV_ACTION);
    run(s(ASI_PRIM), 64'h500, EXC_NONE, mw(64'h500));
    ctx.priv <= 1'b1;
    run(s(ASI_PRIM), 64'h502, EXC_MISALIGNED);
    run(dl(ASI_PRIM), 64'h504, EXC_DBL_MISALIGNED);
    run(mk(5'h06, OP3_LD_QUAD_ALT, 1'b0, {ASI_PRIM, 5'h00}), 64'h504, EXC_ILLEGAL);
    for (int j = 0; j < 3; j++) begin
      ctx.fpu_present <= j != 0;
      ctx.pef <= j != 1;
      ctx.fef <= j != 2;
      run(s(ASI_PRIM), 64'h502, EXC_FPU_DISABLED);
    end
    run(mk(5'h04, OP3_LD_QUAD_ALT, 1'b0, {ASI_PRIM, 5'h00}), 64'h500, EXC_ILLEGAL);
    ctx.fef <= 1'b1;
    run(dl(8'hF0), 64'h540, EXC_NONE, '0, 1'b1);
    run(dl(8'hD8), 64'h540, EXC_NONE, '0, 1'b1);
    fault <= 1'b1;
    run(dl(ASI_PRIM), 64'h600, EXC_DATA_ACCESS);
    fault <= 1'b0;
    wr(REG_FSR_LO, 32'h12345678);
    wr(REG_FSR_HI, 32'h9ABCDEF0);
    ctx.fp_operate_instr_busy <= 1'b1;
    fork
      run(mk(RD_FSR_LOWER, OP3_LD_FSR, 1'b1, 13'h0010), 64'h6F0, EXC_NONE);
      begin
        repeat (6) @(posedge core_clk);
        ctx.fp_operate_instr_busy <= 1'b0;
      end
    join
    run(mk(RD_FSR_LOWER, OP3_LD_FSR, 1'b0, 13'h0020), 64'h700, EXC_ILLEGAL);
    run(mk(5'h02, OP3_LD_FSR, 1'b1, 13'h0000), 64'h700, EXC_ILLEGAL);
    run(mk(RD_FSR_FULL, OP3_LD_FSR, 1'b1, 13'h0000), 64'h700, EXC_NONE, '0, 1'b1);
    run(mk(RD_FSR_LOWER, OP3_LD_FSR, 1'b1, 13'h0002), 64'h700, EXC_MISALIGNED);
    rd(REG_FSR_LO, (32'h12345678 & KEEP) | (mw(64'h700) & ~KEEP));
    rd(REG_FSR_HI, 32'h9ABCDEF0);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0);
    finish_test();
  end
endmodule : fpal_load_unit_tb_top
